// ===== gdis_map.vh
// constants for the instrument-bus interface state block
// assumes byte addresses on the register bus and 7-bit bus codes
`ifndef GDIS_MAP_VH
`define GDIS_MAP_VH

// ********************************************************
// register offsets (byte addresses)
// ********************************************************
`define GDIS_OFS_CTRL      5'h00
`define GDIS_OFS_STATE     5'h04
`define GDIS_OFS_IRQ_STAT  5'h08
`define GDIS_OFS_IRQ_MASK  5'h0C

// ********************************************************
// control register fields
// ********************************************************
`define GDIS_CTRL_SRQ_EN   0
`define GDIS_CTRL_START    1
`define GDIS_CTRL_INIT     2
`define GDIS_CTRL_RESET    1'h0

// ********************************************************
// interrupt event bits
// ********************************************************
`define GDIS_IRQ_W         6
`define GDIS_IRQ_MEAS      0
`define GDIS_IRQ_SYNTAX    1
`define GDIS_IRQ_SRQ       2
`define GDIS_IRQ_IFC       3
`define GDIS_IRQ_DCL       4
`define GDIS_IRQ_TRIG      5
`define GDIS_IRQ_RESET     6'h00

// ********************************************************
// address characters and bus commands
// ********************************************************
`define GDIS_LISTEN_BASE   7'h20
`define GDIS_TALK_BASE     7'h40
`define GDIS_ADDR_MAX      5'h1E
`define GDIS_CMD_UNL       7'h3F
`define GDIS_CMD_UNT       7'h5F
`define GDIS_CMD_DCL       7'h14
`define GDIS_CMD_SDC       7'h04
`define GDIS_CMD_GET       7'h08
`define GDIS_CMD_SPE       7'h18
`define GDIS_CMD_SPD       7'h19

// ********************************************************
// status byte bits
// ********************************************************
`define GDIS_SB_MEAS       0
`define GDIS_SB_SYNTAX     1
`define GDIS_SB_SMOOTH     2
`define GDIS_SB_RQS        6
`define GDIS_SB_RESET      8'h00

`endif

// ===== gdis_sync.v
// two-flop synchroniser for a group of slow pin levels
// assumes the inputs are quasi-static levels, not pulses
`timescale 1ns/1ps

module gdis_sync
#(
   parameter W = 1
)
(
   input  wire         clk,
   input  wire         reset_n,
   input  wire         ce,
   input  wire [W-1:0] d,
   output wire [W-1:0] q
);

   reg [W-1:0] meta_r;
   reg [W-1:0] sync_r;

   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         meta_r <= {W{1'b0}};
         sync_r <= {W{1'b0}};
      end
      else if (ce)
      begin
         meta_r <= d;
         sync_r <= meta_r;
      end
   end

   assign q = sync_r;

endmodule // gdis_sync

// ===== gdis_core.v
// instrument-bus interface state: addressing, flags, status byte, registers
// assumes bus bytes and local events arrive as one-cycle pulses on clk;
// address switch, talk-only switch and interface clear are raw pins
//
// Function
// R1 - listen address is switch plus 0x20, talk address switch plus 0x40
// R2 - talk-only switch forces permanent talker, address ignored
// R3 - in talk-only mode controller idle, others talk-only or listen-only
// R4 - address change waits until the current byte operation finishes
// R5 - after address change the previous address is no longer recognised
// R6 - power-on clears talker, listener, service request, status, transmit data
// R7 - addressed to talk: set talker, clear listener
// R8 - addressed to listen: set listener, clear talker
// R9 - trigger or start code clears transmit data and its status bit only
// R10 - interface clear clears talk/listen; device clear clears srq, status, data
// R11 - unaffected flags hold; unaddress and serial poll clear one flag each
// R12 - srq enabled: measurement done while not talker raises srq, status 65
// R13 - undefined code sets status 66 until next listen addressing; causes OR
// R14 - smoothing full sets smoothing and measurement bits, status 69; the code sets them only while not talker
// R15 - switch inputs pass synchronisers before address comparison
//
// Our own choices: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "gdis_map.vh"

module gdis_core
(
   input  wire        clk,
   input  wire        reset_n,
   input  wire        ce,
   // switch and bus pins
   input  wire [4:0]  address_switch,
   input  wire        talk_only_sw,
   input  wire        ifc_pin,
   // received bus bytes (same clock)
   input  wire        bus_byte_valid,
   input  wire [7:0]  bus_byte,
   input  wire        bus_atn,
   input  wire        tx_byte_taken,
   // local events (same clock)
   input  wire        meas_done,
   input  wire        smooth_full,
   input  wire        syntax_err,
   input  wire        start_code,
   input  wire        init_code,
   // flags
   output reg         talker_r,
   output reg         listener_r,
   output reg         srq_r,
   output reg  [7:0]  status_byte_r,
   output reg         tx_pending_r,
   output reg         spoll_mode_r,
   output reg  [4:0]  active_addr_r,
   output wire        irq,
   // avalon-mm slave
   input  wire [4:0]  address,
   input  wire        read,
   input  wire        write,
   input  wire [31:0] writedata,
   output reg  [31:0] readdata,
   output wire        waitrequest
);

   // ********************************************************
   // pin synchronisers
   // ********************************************************
   wire [6:0] pin_sync;
   wire [4:0] sw_addr;
   wire       sw_talk_only;
   wire       ifc_sync;

   gdis_sync #(.W(7)) u_sync                                // R15
   (
      .clk     (clk),
      .reset_n (reset_n),
      .ce      (ce),
      .d       ({ifc_pin, talk_only_sw, address_switch}),
      .q       (pin_sync)
   );

   assign sw_addr      = pin_sync[4:0];
   assign sw_talk_only = pin_sync[5];
   assign ifc_sync     = pin_sync[6];

   // interface clear acts on its rising level edge
   reg  ifc_d_r;
   wire ifc_evt;
   assign ifc_evt = ifc_sync & ~ifc_d_r;

   // ********************************************************
   // active address
   // ********************************************************
   // a byte in flight is decoded against the old address; the new one
   // takes over between bytes, so the old address is dead from then on
   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         active_addr_r <= 5'h00;
         ifc_d_r       <= 1'b0;
      end
      else if (ce)
      begin
         ifc_d_r <= ifc_sync;
         if (!bus_byte_valid && sw_addr <= `GDIS_ADDR_MAX)     // R4
            active_addr_r <= sw_addr;                           // R5
      end
   end

   // ********************************************************
   // command decode
   // ********************************************************
   wire [6:0] code;
   wire [6:0] my_listen;
   wire [6:0] my_talk;
   wire       cmd;
   wire       is_mla;
   wire       is_mta;
   wire       is_unl;
   wire       is_unt;
   wire       is_dcl;
   wire       is_get;
   wire       is_spe;
   wire       is_spd;
   wire       dev_clear;
   wire       trigger;
   wire       spoll_done;

   assign code      = bus_byte[6:0];
   assign my_listen = `GDIS_LISTEN_BASE + {2'b00, active_addr_r};   // R1
   assign my_talk   = `GDIS_TALK_BASE + {2'b00, active_addr_r};     // R1
   // talk-only ignores addressing from the bus; the controller must stay idle
   assign cmd       = bus_byte_valid & bus_atn & ~sw_talk_only;     // R2 R3
   assign is_mla    = cmd & (code == my_listen);
   assign is_mta    = cmd & (code == my_talk);
   assign is_unl    = cmd & (code == `GDIS_CMD_UNL);
   assign is_unt    = cmd & (code == `GDIS_CMD_UNT);
   assign is_dcl    = cmd & ((code == `GDIS_CMD_DCL) |
                             (listener_r & (code == `GDIS_CMD_SDC)));
   assign is_get    = cmd & listener_r & (code == `GDIS_CMD_GET);
   assign is_spe    = cmd & (code == `GDIS_CMD_SPE);
   assign is_spd    = cmd & (code == `GDIS_CMD_SPD);

   // ********************************************************
   // register bus front end
   // ********************************************************
   reg                   ack_r;
   reg                   srq_en_r;
   reg [`GDIS_IRQ_W-1:0] irq_stat_r;
   reg [`GDIS_IRQ_W-1:0] irq_mask_r;
   wire                  wr_go;
   wire                  sw_start;
   wire                  sw_init;

   // every access takes one wait cycle, answered on the second edge
   assign waitrequest = (read | write) & ~ack_r;
   assign wr_go       = write & ack_r;
   assign sw_start    = wr_go & (address == `GDIS_OFS_CTRL) & writedata[`GDIS_CTRL_START];
   assign sw_init     = wr_go & (address == `GDIS_OFS_CTRL) & writedata[`GDIS_CTRL_INIT];

   assign dev_clear  = is_dcl | init_code | sw_init;                // R10
   assign trigger    = is_get | start_code | sw_start;              // R9
   assign spoll_done = spoll_mode_r & talker_r & tx_byte_taken;

   // ********************************************************
   // talker / listener / serial poll mode
   // ********************************************************
   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         talker_r     <= 1'b0;                                 // R6
         listener_r   <= 1'b0;                                 // R6
         spoll_mode_r <= 1'b0;
      end
      else if (ce)
      begin
         if (sw_talk_only)
         begin
            talker_r     <= 1'b1;                              // R2
            listener_r   <= 1'b0;
            spoll_mode_r <= 1'b0;
         end
         else if (ifc_evt)
         begin
            talker_r     <= 1'b0;                              // R10
            listener_r   <= 1'b0;                              // R10
            spoll_mode_r <= 1'b0;
         end
         else
         begin
            if (is_mta)
            begin
               talker_r   <= 1'b1;                             // R7
               listener_r <= 1'b0;                             // R7
            end
            else if (is_mla)
            begin
               listener_r <= 1'b1;                             // R8
               talker_r   <= 1'b0;                             // R8
            end
            else if (is_unt)
               talker_r <= 1'b0;                               // R11
            else if (is_unl)
               listener_r <= 1'b0;                             // R11
            if (is_spe)
               spoll_mode_r <= 1'b1;
            else if (is_spd)
               spoll_mode_r <= 1'b0;
         end
      end
   end

   // ********************************************************
   // status byte, service request and transmit data
   // ********************************************************
   reg        sb_meas_nxt;
   reg        sb_syn_nxt;
   reg        sb_smooth_nxt;
   reg        srq_nxt;
   reg        tx_nxt;
   wire       meas_evt;
   wire       any_bit;

   // a measurement while addressed to talk goes straight out as data
   assign meas_evt = (meas_done | smooth_full) & ~talker_r;        // R12
   assign any_bit  = sb_meas_nxt | sb_syn_nxt | sb_smooth_nxt;

   always @*
   begin
      sb_meas_nxt   = status_byte_r[`GDIS_SB_MEAS];
      sb_syn_nxt    = status_byte_r[`GDIS_SB_SYNTAX];
      sb_smooth_nxt = status_byte_r[`GDIS_SB_SMOOTH];
      srq_nxt       = srq_r;
      tx_nxt        = tx_pending_r;
      // clears first, so an event in the same cycle still sets
      if (is_mta)
      begin
         sb_meas_nxt   = 1'b0;
         sb_smooth_nxt = 1'b0;                                 // R14
      end
      if (is_mla)
         sb_syn_nxt = 1'b0;                                    // R13
      if (trigger)
      begin
         sb_meas_nxt   = 1'b0;                                 // R9
         sb_smooth_nxt = 1'b0;                                 // R14
         tx_nxt        = 1'b0;                                 // R9
      end
      if (dev_clear)
      begin
         sb_meas_nxt   = 1'b0;                                 // R10
         sb_syn_nxt    = 1'b0;
         sb_smooth_nxt = 1'b0;
         srq_nxt       = 1'b0;
         tx_nxt        = 1'b0;
      end
      if (spoll_done)
         srq_nxt = 1'b0;                                       // R11
      if (meas_done | smooth_full)
         tx_nxt = 1'b1;
      if (meas_evt)
      begin
         sb_meas_nxt = 1'b1;                                   // R12
         if (srq_en_r)
            srq_nxt = 1'b1;                                    // R12
      end
      if (smooth_full & ~talker_r)
         sb_smooth_nxt = 1'b1;                                 // R14
      if (syntax_err)
      begin
         sb_syn_nxt = 1'b1;                                    // R13
         if (srq_en_r)
            srq_nxt = 1'b1;
      end
   end

   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         status_byte_r <= `GDIS_SB_RESET;                      // R6
         srq_r         <= 1'b0;                                // R6
         tx_pending_r  <= 1'b0;                                // R6
      end
      else if (ce)
      begin
         // status bits OR together when causes coincide
         status_byte_r <= {1'b0, any_bit, 3'b000,
                           sb_smooth_nxt, sb_syn_nxt, sb_meas_nxt};   // R13
         srq_r         <= srq_nxt;
         tx_pending_r  <= tx_nxt;
      end
   end

   // ********************************************************
   // registers and interrupt
   // ********************************************************
   wire [`GDIS_IRQ_W-1:0] irq_evt;
   wire                   wr_stat;

   assign irq_evt = {trigger, dev_clear, ifc_evt, srq_nxt & ~srq_r,
                     syntax_err, meas_done};
   assign wr_stat = wr_go & (address == `GDIS_OFS_IRQ_STAT);
   assign irq     = |(irq_stat_r & irq_mask_r);

   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         ack_r      <= 1'b0;
         srq_en_r   <= `GDIS_CTRL_RESET;
         irq_stat_r <= `GDIS_IRQ_RESET;
         irq_mask_r <= `GDIS_IRQ_RESET;
         readdata   <= 32'h00000000;
      end
      else if (ce)
      begin
         ack_r <= (read | write) & ~ack_r;
         // event set wins over a write-one clear in the same cycle
         if (wr_stat)
            irq_stat_r <= (irq_stat_r & ~writedata[`GDIS_IRQ_W-1:0]) | irq_evt;
         else
            irq_stat_r <= irq_stat_r | irq_evt;
         if (wr_go && address == `GDIS_OFS_CTRL)
            srq_en_r <= writedata[`GDIS_CTRL_SRQ_EN];
         if (wr_go && address == `GDIS_OFS_IRQ_MASK)
            irq_mask_r <= writedata[`GDIS_IRQ_W-1:0];
         if (read && !ack_r)
         begin
            case (address)
               `GDIS_OFS_CTRL:
                  readdata <= {31'h00000000, srq_en_r};
               `GDIS_OFS_STATE:
                  readdata <= {8'h00, status_byte_r, 3'b000, active_addr_r,
                               1'b0, sw_talk_only, spoll_mode_r, tx_pending_r,
                               srq_r, listener_r, talker_r, ifc_sync};
               `GDIS_OFS_IRQ_STAT:
                  readdata <= {26'h0000000, irq_stat_r};
               `GDIS_OFS_IRQ_MASK:
                  readdata <= {26'h0000000, irq_mask_r};
               default:
                  readdata <= 32'h00000000;
            endcase
         end
      end
   end

endmodule // gdis_core

// ===== gdis_core_props.sv
// concurrent checks on the ports of the bus-interface state block
// assumes one clock domain with async active-low reset; bound from tb_top
`timescale 1ns/1ps

module gdis_core_props
(
   input wire       clk,
   input wire       reset_n,
   input wire       ce,
   input wire [4:0] address_switch,
   input wire       talk_only_sw,
   input wire       ifc_pin,
   input wire       bus_byte_valid,
   input wire [7:0] bus_byte,
   input wire       bus_atn,
   input wire       tx_byte_taken,
   input wire       meas_done,
   input wire       smooth_full,
   input wire       syntax_err,
   input wire       start_code,
   input wire       init_code,
   input wire       talker_r,
   input wire       listener_r,
   input wire       srq_r,
   input wire [7:0] status_byte_r,
   input wire       tx_pending_r,
   input wire       spoll_mode_r,
   input wire [4:0] active_addr_r
);
   // ************
   // helpers
   // ************
   default clocking dcb @(posedge clk); endclocking
   default disable iff (!reset_n);
   // raw pin levels stand in for their synced copies; the bench holds them for many cycles
   wire       cmd  = ce && bus_byte_valid && bus_atn && !talk_only_sw && !ifc_pin;
   wire       ev   = meas_done | smooth_full | syntax_err | start_code | init_code;
   wire [6:0] code = bus_byte[6:0];
   sequence s_poll;
      ce && spoll_mode_r && talker_r && tx_byte_taken && !ev && !bus_byte_valid;
   endsequence

   AST_PWR: assert property ($rose(reset_n) |-> !talker_r && !listener_r && !srq_r
      && !tx_pending_r && status_byte_r == 8'h00) else $error("flags set after reset");
   AST_MTA: assert property (cmd && code == {2'h2, active_addr_r}
      |=> talker_r && !listener_r) else $error("talk addressing failed");
   AST_MLA: assert property (cmd && code == {2'h1, active_addr_r}
      |=> listener_r && !talker_r) else $error("listen addressing failed");
   AST_UNT: assert property (cmd && code == 7'h5F
      |=> !talker_r && $stable(listener_r)) else $error("talker unaddress wrong");
   AST_UNL: assert property (cmd && code == 7'h3F
      |=> !listener_r && $stable(talker_r)) else $error("listener unaddress wrong");
   AST_POLL: assert property (s_poll
      |=> !srq_r && $stable(status_byte_r) && $stable(talker_r)) else $error("poll wrong");
   AST_GET: assert property (cmd && listener_r && code == 7'h08 && !ev
      |=> !tx_pending_r && !status_byte_r[0] && $stable({talker_r, listener_r}))
      else $error("trigger clear wrong");
   AST_DCL: assert property (cmd && (code == 7'h14 || listener_r && code == 7'h04) && !ev
      |=> !srq_r && !tx_pending_r && status_byte_r == 8'h00) else $error("device clear wrong");
   AST_IFC: assert property (ifc_pin [*6] |-> !talker_r && !listener_r)
      else $error("interface clear ignored");
   AST_TONLY: assert property (talk_only_sw [*6] |-> talker_r)
      else $error("talk-only not talker");
   AST_SB: assert property (status_byte_r == {1'h0, |status_byte_r[2:0], 3'h0, status_byte_r[2:0]})
      else $error("status byte malformed");
   AST_SMOOTH: assert property (ce && smooth_full && !talker_r && !cmd
      |=> status_byte_r[2] && status_byte_r[0]) else $error("smoothing bits wrong");
   AST_SYNTAX: assert property (ce && syntax_err |=> status_byte_r[1])
      else $error("syntax bit not set");
   AST_HOLD: assert property ($changed(address_switch) |=> $stable(active_addr_r) [*2])
      else $error("address taken without sync");
endmodule // gdis_core_props

// ===== gdis_ctl_model.sv
// far-side controller model: sends command bytes, accepts talker bytes, pulses clear
// assumes callers enter its tasks right after a rising edge of clk
`timescale 1ns/1ps

module gdis_ctl_model
(
   input  wire        clk,
   input  wire        talk_only,
   output logic       bus_byte_valid,
   output logic [7:0] bus_byte,
   output logic       bus_atn,
   output logic       tx_byte_taken,
   output logic       ifc_pin
);
   initial
   begin
      bus_byte_valid = 1'h0;
      bus_byte       = 8'h00;
      bus_atn        = 1'h0;
      tx_byte_taken  = 1'h0;
      ifc_pin        = 1'h0;
   end

   task send(input logic [7:0] b, input int gap);
      begin
         if (!talk_only)
         begin
            bus_byte       <= b;
            bus_atn        <= 1'h1;
            bus_byte_valid <= 1'h1;
            @(posedge clk);
            // released lines show the inverse so a stale byte never looks valid
            bus_byte       <= ~b;
            bus_atn        <= 1'h0;
            bus_byte_valid <= 1'h0;
            repeat (gap) @(posedge clk);
         end
      end
   endtask

   task take();
      begin
         tx_byte_taken <= 1'h1;
         @(posedge clk);
         tx_byte_taken <= 1'h0;
         @(posedge clk);
      end
   endtask

   task clear();
      begin
         ifc_pin <= 1'h1;
         repeat (8) @(posedge clk);
         ifc_pin <= 1'h0;
         repeat (6) @(posedge clk);
      end
   endtask
endmodule // gdis_ctl_model

// ===== tb_top.sv
// self-checking bench for the bus-interface state block
// assumes gdis_core, gdis_ctl_model and gdis_core_props are compiled first
`timescale 1ns/1ps
`include "gdis_map.vh"

module tb_top;
   logic        clk            = 1'h0;
   logic        reset_n        = 1'h0;
   logic        ce             = 1'h1;
   logic        talk_only_sw   = 1'h0;
   logic        read           = 1'h0;
   logic        write          = 1'h0;
   logic [4:0]  address_switch = 5'h05;
   logic [4:0]  address        = 5'h00;
   logic [4:0]  ev             = 5'h00;
   logic [31:0] writedata      = 32'h0;
   logic [31:0] rdat;
   logic [7:0]  adr_cmd [6]    = '{8'h25, 8'h45, 8'h5F, 8'h25, 8'h5F, 8'h3F};
   logic [31:0] adr_exp [6]    = '{32'h200, 32'h400, 32'h0, 32'h200, 32'h200, 32'h0};
   wire         bus_byte_valid, bus_atn, tx_byte_taken, ifc_pin, talker_r, listener_r;
   wire         srq_r, tx_pending_r, spoll_mode_r, irq, waitrequest;
   wire [7:0]   bus_byte, status_byte_r;
   wire [4:0]   active_addr_r;
   wire [31:0]  readdata;
   int          n_mismatch     = 0;
   int          n_checks       = 0;

   always #5 clk = ~clk;

   gdis_ctl_model ctl_inst (.clk(clk), .talk_only(talk_only_sw), .bus_byte_valid(bus_byte_valid),
      .bus_byte(bus_byte), .bus_atn(bus_atn), .tx_byte_taken(tx_byte_taken), .ifc_pin(ifc_pin));

   gdis_core gdis_core_inst (.clk(clk), .reset_n(reset_n), .ce(ce),
      .address_switch(address_switch), .talk_only_sw(talk_only_sw), .ifc_pin(ifc_pin),
      .bus_byte_valid(bus_byte_valid), .bus_byte(bus_byte), .bus_atn(bus_atn),
      .tx_byte_taken(tx_byte_taken), .meas_done(ev[0]), .smooth_full(ev[1]),
      .syntax_err(ev[2]), .start_code(ev[3]), .init_code(ev[4]), .talker_r(talker_r),
      .listener_r(listener_r), .srq_r(srq_r), .status_byte_r(status_byte_r),
      .tx_pending_r(tx_pending_r), .spoll_mode_r(spoll_mode_r), .active_addr_r(active_addr_r),
      .irq(irq), .address(address), .read(read), .write(write), .writedata(writedata),
      .readdata(readdata), .waitrequest(waitrequest));

   // ************
   // tasks
   // ************
   function automatic logic [31:0] fl();
      return {21'h0, talker_r, listener_r, srq_r, status_byte_r};
   endfunction

   task chk(input logic [31:0] got, input logic [31:0] exp);
      begin
         n_checks++;
         if (got !== exp)
         begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask

   task av(input logic wr, input logic [4:0] a, input logic [31:0] d);
      logic w;
      int   i;
      begin
         address   <= a;
         writedata <= d;
         write     <= wr;
         read      <= !wr;
         i = 0;
         w = 1'h1;
         // read in the active region of the edge, before that edge's own updates land
         while (w !== 1'h0 && i < 40)
         begin
            @(posedge clk);
            w = waitrequest;
            i++;
         end
         if (w !== 1'h0) n_mismatch++;
         rdat = readdata;
         read  <= 1'h0;
         write <= 1'h0;
         @(posedge clk);
      end
   endtask

   task rd(input logic [4:0] a, input logic [31:0] exp);
      begin
         av(1'h0, a, 32'h0);
         chk(rdat, exp);
      end
   endtask

   task pulse(input int i);
      begin
         ev <= 5'h01 << i;
         @(posedge clk);
         ev <= 5'h00;
         repeat (2) @(posedge clk);
      end
   endtask

   task complete_run();
      begin
         if (n_mismatch == 0 && n_checks > 0)
            $display("All tests passed");
         else
            $display("Some tests failed");
         $finish;
      end
   endtask

   // ************
   // scenarios
   // ************
   initial
   begin
      repeat (6) @(posedge clk);
      reset_n <= 1'h1;
      repeat (4) @(posedge clk);
      chk(fl(), 32'h0);
      rd(`GDIS_OFS_STATE, 32'h0000_0500);
      rd(`GDIS_OFS_IRQ_MASK, 32'h0);
      rd(5'h10, 32'h0);
      for (int k = 0; k < 6; k++)
      begin
         ctl_inst.send(adr_cmd[k], 1 + 2 * (k % 2));
         chk(fl(), adr_exp[k]);
      end
      address_switch <= `GDIS_ADDR_MAX;
      repeat (6) @(posedge clk);
      ctl_inst.send(8'h45, 1);
      chk(fl(), 32'h0);
      ctl_inst.send(8'h5E, 1);
      rd(`GDIS_OFS_STATE, 32'h0000_1E02);
      address_switch <= 5'h1F;
      repeat (6) @(posedge clk);
      chk({27'h0, active_addr_r}, 32'h1E);
      address_switch <= 5'h05;
      repeat (6) @(posedge clk);
      av(1'h1, `GDIS_OFS_CTRL, 32'h1);
      av(1'h1, `GDIS_OFS_IRQ_MASK, 32'h1);
      ctl_inst.send(`GDIS_CMD_UNT, 1);
      pulse(0);
      chk(fl(), 32'h141);
      chk({31'h0, irq}, 32'h1);
      pulse(2);
      chk(fl(), 32'h143);
      ctl_inst.send(8'h25, 1);
      chk(fl(), 32'h341);
      pulse(1);
      chk(fl(), 32'h345);
      av(1'h1, `GDIS_OFS_IRQ_STAT, 32'h3F);
      pulse(2);
      chk({31'h0, irq}, 32'h0);
      rd(`GDIS_OFS_IRQ_STAT, 32'h2);
      ctl_inst.send(`GDIS_CMD_SPE, 1);
      ctl_inst.send(8'h45, 1);
      ctl_inst.take();
      chk(fl(), 32'h442);
      chk({31'h0, spoll_mode_r}, 32'h1);
      ctl_inst.send(`GDIS_CMD_SPD, 1);
      chk({31'h0, spoll_mode_r}, 32'h0);
      ctl_inst.send(8'h25, 1);
      for (int k = 0; k < 7; k++)
      begin
         pulse(0);
         case (k)
            0: ctl_inst.send(`GDIS_CMD_GET, 1);
            1: av(1'h1, `GDIS_OFS_CTRL, 32'h3);
            2: pulse(3);
            3: ctl_inst.send(`GDIS_CMD_DCL, 1);
            4: ctl_inst.send(`GDIS_CMD_SDC, 1);
            5: av(1'h1, `GDIS_OFS_CTRL, 32'h5);
            default: pulse(4);
         endcase
         repeat (2) @(posedge clk);
         chk(fl(), k < 3 ? 32'h300 : 32'h200);
         chk({31'h0, tx_pending_r}, 32'h0);
      end
      rd(`GDIS_OFS_CTRL, 32'h1);
      ctl_inst.send(8'h45, 1);
      pulse(2);
      chk(fl(), 32'h542);
      ctl_inst.clear();
      chk(fl(), 32'h142);
      rd(`GDIS_OFS_IRQ_STAT, 32'h3F);
      talk_only_sw <= 1'h1;
      repeat (6) @(posedge clk);
      ctl_inst.send(8'h25, 1);
      chk(fl(), 32'h542);
      complete_run();
   end

   initial
   begin
      repeat (5000) @(posedge clk);
      n_mismatch++;
      complete_run();
   end
endmodule // tb_top

bind gdis_core gdis_core_props gdis_core_props_inst (.clk(clk), .reset_n(reset_n), .ce(ce),
   .address_switch(address_switch), .talk_only_sw(talk_only_sw), .ifc_pin(ifc_pin),
   .bus_byte_valid(bus_byte_valid), .bus_byte(bus_byte), .bus_atn(bus_atn),
   .tx_byte_taken(tx_byte_taken), .meas_done(meas_done), .smooth_full(smooth_full),
   .syntax_err(syntax_err), .start_code(start_code), .init_code(init_code),
   .talker_r(talker_r), .listener_r(listener_r), .srq_r(srq_r), .status_byte_r(status_byte_r),
   .tx_pending_r(tx_pending_r), .spoll_mode_r(spoll_mode_r), .active_addr_r(active_addr_r));
